// File: src/pwr_wake_pkg.sv
// power state and wake controller: shared constants, states and carriers
// assumes a 125 MHz always-on standby clock
package pwr_wake_pkg;

   localparam int unsigned CLK_HZ           = 125_000_000;
   localparam int unsigned SHORT_PRESS_S    = 4;
   localparam int unsigned LONG_PRESS_S     = 6;
   localparam int unsigned DEBOUNCE_MS      = 20;
   localparam int unsigned CNT_W            = 30;
   localparam logic [CNT_W-1:0] SHORT_CYC   = CNT_W'(SHORT_PRESS_S * CLK_HZ);
   localparam logic [CNT_W-1:0] LONG_CYC    = CNT_W'(LONG_PRESS_S * CLK_HZ);
   localparam logic [CNT_W-1:0] DEBOUNCE_CYC = CNT_W'(DEBOUNCE_MS * (CLK_HZ / 1000));
   localparam logic [CNT_W-1:0] CNT_ZERO    = 30'h0000000;
   localparam logic [CNT_W-1:0] CNT_ONE     = 30'h0000001;

   // sleep request codes from the operating system
   localparam logic [1:0] REQ_S3 = 2'h0;
   localparam logic [1:0] REQ_S4 = 2'h1;
   localparam logic [1:0] REQ_S5 = 2'h2;

   // ac restore policy
   localparam logic [1:0] AC_STAY_OFF = 2'h0;
   localparam logic [1:0] AC_POWER_ON = 2'h1;
   localparam logic [1:0] AC_LAST     = 2'h2;

   typedef enum logic [3:0] {
      ST_S0 = 4'h1,
      ST_S3 = 4'h2,
      ST_S4 = 4'h4,
      ST_S5 = 4'h8
   } pwr_state_t;

   typedef struct packed {
      logic power_switch;
      logic rtc_alarm;
      logic lan_wake;
      logic usb_wake;
      logic pcie_wake_n;
      logic cir_wake;
   } wake_in_t;

   typedef struct packed {
      logic main_power_on;
      logic usb_port_power;
      logic led_green;
      logic led_amber;
   } pwr_out_t;

endpackage

// File: src/power_state_wake_control.sv
// power state and wake controller for the always-on standby domain
// assumes all inputs synchronous to clk, the switch input raw (bouncing)
`timescale 1ns/10ps

module power_state_wake_control (
   input  wire  logic                    clk,
   input  wire  logic                    resetn,
   input  wire  pwr_wake_pkg::wake_in_t  wake_in,
   input  wire  logic                    os_sleep_req,
   input  wire  logic [1:0]              os_sleep_type,
   input  wire  logic                    os_s4_wake_ok,
   input  wire  logic                    deepest_sleep_option,
   input  wire  logic [1:0]              ac_restore_mode,
   input  wire  logic                    last_state_on,
   input  wire  logic                    led_dual_colour,
   output logic                          lan_monitor_en,
   output logic                          system_on_r,
   output pwr_wake_pkg::pwr_out_t        pwr_out,
   output pwr_wake_pkg::pwr_state_t      state
);
   import pwr_wake_pkg::*;

   // ----------------------------------------------------------------
   // switch debounce and press timing
   // ----------------------------------------------------------------
   logic             sw_raw_r, sw_raw_nxt;
   logic             sw_deb_r, sw_deb_nxt;
   logic [CNT_W-1:0] deb_cnt_r, deb_cnt_nxt;
   logic [CNT_W-1:0] hold_cnt_r, hold_cnt_nxt;
   logic             short_rel, long_hold;
   logic             long_done_r, long_done_nxt;

   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      sat_inc = (v == LONG_CYC) ? v : v + CNT_ONE;
   endfunction

   always_comb begin
      sw_raw_nxt    = wake_in.power_switch;
      sw_deb_nxt    = sw_deb_r;
      deb_cnt_nxt   = CNT_ZERO;
      hold_cnt_nxt  = hold_cnt_r;
      long_done_nxt = long_done_r;
      short_rel     = 1'b0;
      long_hold     = 1'b0;
      if (sw_raw_r != sw_deb_r) begin
         deb_cnt_nxt = sat_inc(deb_cnt_r);
         if (deb_cnt_r >= DEBOUNCE_CYC) begin
            sw_deb_nxt  = sw_raw_r;
            deb_cnt_nxt = CNT_ZERO;
         end
      end
      if (sw_deb_r) begin
         hold_cnt_nxt = sat_inc(hold_cnt_r);
         // fire the forced off while still held, once per press
         if (hold_cnt_r == LONG_CYC && !long_done_r) begin
            long_hold     = 1'b1;
            long_done_nxt = 1'b1;
         end
      end else begin
         // anything released before six seconds counts as short
         if (hold_cnt_r != CNT_ZERO && !long_done_r) begin
            short_rel = 1'b1;
         end
         hold_cnt_nxt  = CNT_ZERO;
         long_done_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         sw_raw_r    <= 1'b0;
         sw_deb_r    <= 1'b0;
         deb_cnt_r   <= CNT_ZERO;
         hold_cnt_r  <= CNT_ZERO;
         long_done_r <= 1'b0;
      end else begin
         sw_raw_r    <= sw_raw_nxt;
         sw_deb_r    <= sw_deb_nxt;
         deb_cnt_r   <= deb_cnt_nxt;
         hold_cnt_r  <= hold_cnt_nxt;
         long_done_r <= long_done_nxt;
      end
   end

   // ----------------------------------------------------------------
   // wake latching
   // ----------------------------------------------------------------
   logic       wake_r, wake_nxt;
   logic [5:0] src_prev_r, src_now;
   logic       rtc_e, lan_e, usb_e, pcie_e, cir_e, ext_wake;

   always_comb begin
      // rising edges only: a level held high cannot retrigger after power-up
      src_now = {1'b0, wake_in.rtc_alarm, wake_in.lan_wake, wake_in.usb_wake,
                 ~wake_in.pcie_wake_n, wake_in.cir_wake};
      rtc_e  = src_now[4] & ~src_prev_r[4];
      lan_e  = src_now[3] & ~src_prev_r[3];
      usb_e  = src_now[2] & ~src_prev_r[2];
      pcie_e = src_now[1] & ~src_prev_r[1];
      cir_e  = src_now[0] & ~src_prev_r[0];
      ext_wake = 1'b0;
      if (state != ST_S0 && !(state == ST_S4 && !os_s4_wake_ok)) begin
         if (deepest_sleep_option && state != ST_S3) begin
            ext_wake = rtc_e;
         end else begin
            ext_wake = rtc_e | lan_e | pcie_e | cir_e
                     | (usb_e & (state == ST_S3));
         end
      end
      // latch, drop once working so one event starts one power-up
      wake_nxt = (state == ST_S0) ? 1'b0 : (wake_r | ext_wake);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wake_r     <= 1'b0;
         src_prev_r <= 6'h00;
      end else begin
         wake_r     <= wake_nxt;
         src_prev_r <= src_now;
      end
   end

   // ----------------------------------------------------------------
   // global state machine
   // ----------------------------------------------------------------
   pwr_state_t state_r, state_nxt;
   logic       restore_done_r, restore_done_nxt;

   always_comb begin
      state_nxt        = state_r;
      restore_done_nxt = 1'b1;
      if (!restore_done_r) begin
         // first cycle after standby power returns
         case (ac_restore_mode)
            AC_POWER_ON: state_nxt = ST_S0;
            AC_LAST:     state_nxt = last_state_on ? ST_S0 : ST_S5;
            default:     state_nxt = ST_S5;
         endcase
      end else begin
         case (state_r)
            ST_S0: begin
               if (long_hold) begin
                  state_nxt = ST_S5;
               end else if (short_rel || os_sleep_req) begin
                  case (os_sleep_type)
                     REQ_S3:  state_nxt = ST_S3;
                     REQ_S4:  state_nxt = ST_S4;
                     default: state_nxt = ST_S5;
                  endcase
               end
            end
            ST_S3, ST_S4: begin
               if (long_hold) begin
                  state_nxt = ST_S5;
               end else if (short_rel || wake_r) begin
                  state_nxt = ST_S0;
               end
            end
            ST_S5: begin
               if (short_rel || wake_r) begin
                  state_nxt = ST_S0;
               end
            end
            default: state_nxt = ST_S5;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_r        <= ST_S5;
         restore_done_r <= 1'b0;
      end else begin
         state_r        <= state_nxt;
         restore_done_r <= restore_done_nxt;
      end
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   pwr_out_t pwr_out_nxt;
   logic     lan_mon_nxt;

   always_comb begin
      pwr_out_nxt.main_power_on  = (state_nxt == ST_S0);
      pwr_out_nxt.usb_port_power = (state_nxt == ST_S0) || (state_nxt == ST_S3);
      pwr_out_nxt.led_green      = (state_nxt == ST_S0);
      pwr_out_nxt.led_amber      = (state_nxt == ST_S3) && led_dual_colour;
      lan_mon_nxt = (state_nxt != ST_S0) &&
                    !(deepest_sleep_option && state_nxt != ST_S3);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         pwr_out        <= '0;
         lan_monitor_en <= 1'b0;
         system_on_r    <= 1'b0;
         state          <= ST_S5;
      end else begin
         pwr_out        <= pwr_out_nxt;
         lan_monitor_en <= lan_mon_nxt;
         system_on_r    <= (state_nxt == ST_S0);
         state          <= state_nxt;
      end
   end

endmodule

// File: tb/wake_source_model.sv
// wake source model: bench command word to wake source levels
// assumes cmd bits 5 switch, 4 rtc, 3 lan, 2 usb, 1 pcie, 0 ir
`timescale 1ns/10ps
module wake_source_model (
   input  wire logic [5:0]        cmd,
   output pwr_wake_pkg::wake_in_t wake_in
);
   import pwr_wake_pkg::*;
   // pcie wake idles pulled high and is low only while a request is held
   assign wake_in = wake_in_t'(cmd ^ 6'h02);
endmodule

// File: tb/power_state_wake_control_checker.sv
// checker: state, wake and output timing of the power controller
// assumes one clock domain; bound to every controller instance
`timescale 1ns/10ps
module power_state_wake_control_checker (
   input wire logic                     clk,
   input wire logic                     resetn,
   input wire pwr_wake_pkg::wake_in_t   wake_in,
   input wire logic                     os_sleep_req,
   input wire logic [1:0]               os_sleep_type,
   input wire logic                     os_s4_wake_ok,
   input wire logic                     deepest_sleep_option,
   input wire logic [1:0]               ac_restore_mode,
   input wire logic                     last_state_on,
   input wire logic                     led_dual_colour,
   input wire logic                     lan_monitor_en,
   input wire logic                     system_on_r,
   input wire pwr_wake_pkg::pwr_out_t   pwr_out,
   input wire pwr_wake_pkg::pwr_state_t state
);
   import pwr_wake_pkg::*;
   // ------------------------------------------------
   // properties
   // ------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   a_usb_s3_only: assert property (
      $past(resetn) && state inside {ST_S4, ST_S5} && $rose(wake_in.usb_wake) |-> ##2 state != ST_S0)
      else $error("usb woke from S4 or S5");
   a_amber_s3: assert property (
      state == ST_S3 && $stable(state) && $stable(led_dual_colour) |-> pwr_out.led_amber == led_dual_colour)
      else $error("amber wrong in S3");
   a_rtc_wakes: assert property (
      $past(resetn) && state != ST_S0 && (state != ST_S4 || os_s4_wake_ok) && $rose(wake_in.rtc_alarm)
      |-> ##2 state == ST_S0) else $error("rtc wake missed");
   a_os_request: assert property (
      state == ST_S0 && os_sleep_req
      |=> state == ($past(os_sleep_type[1]) ? ST_S5 : 4'h2 << $past(os_sleep_type))) else $error("bad sleep");
   // a limited deep state also stops the lan monitor, so only the positive case is pinned
   a_lan_monitor: assert property (
      $past(resetn, 2) && $stable(state) && $stable(deepest_sleep_option) && state != ST_S0
      && !(deepest_sleep_option && state != ST_S3) |-> lan_monitor_en) else $error("lan monitor off");
   a_deep_blocks: assert property (
      $past(resetn) && deepest_sleep_option && state == ST_S5 && ($rose(wake_in.lan_wake) || $rose(wake_in.cir_wake))
      |-> ##2 state == ST_S5) else $error("deep sleep woke");
   a_pcie_wakes: assert property (
      $past(resetn) && !deepest_sleep_option && state inside {ST_S3, ST_S5} && $fell(wake_in.pcie_wake_n)
      |-> ##2 system_on_r) else $error("pcie wake missed");
   a_ac_restore: assert property (
      !$past(resetn) |-> ##2 system_on_r == ($past(ac_restore_mode, 2) == AC_POWER_ON
      || $past(ac_restore_mode, 2) == AC_LAST && $past(last_state_on, 2))) else $error("ac restore wrong");
   c_wake_s4: cover property (state == ST_S4 ##1 state == ST_S0);
   c_deep_rtc: cover property (deepest_sleep_option && state == ST_S5 ##1 state == ST_S0);
   c_amber: cover property (pwr_out.led_amber);
endmodule

bind power_state_wake_control power_state_wake_control_checker i_power_state_wake_control_checker (
   .clk, .resetn, .wake_in, .os_sleep_req, .os_sleep_type, .os_s4_wake_ok, .deepest_sleep_option,
   .ac_restore_mode, .last_state_on, .led_dual_colour, .lan_monitor_en, .system_on_r, .pwr_out, .state);

// File: tb/power_state_wake_control_tb_top.sv
// bench: ac restore, os sleep requests, every wake source but the power switch in every sleep state
// assumes the wake source model and the bound checker beside the controller
`timescale 1ns/10ps
module power_state_wake_control_tb_top;
   import pwr_wake_pkg::*;
   logic       clk = 1'b0;
   logic       resetn = 1'b0;
   logic [5:0] cmd = 6'h00;
   logic       os_sleep_req = 1'b0;
   logic [1:0] os_sleep_type = 2'h0;
   logic       os_s4_wake_ok = 1'b1;
   logic       deepest_sleep_option = 1'b0;
   logic [1:0] ac_restore_mode = 2'h0;
   logic       last_state_on = 1'b0;
   logic       led_dual_colour = 1'b0;
   wake_in_t   wake_in;
   logic       lan_monitor_en;
   logic       system_on_r;
   pwr_out_t   pwr_out;
   pwr_state_t state;
   int         fails = 0;
   int         comparisons = 0;

   wake_source_model i_wake_source_model (.cmd, .wake_in);
   power_state_wake_control i_power_state_wake_control (.clk, .resetn, .wake_in, .os_sleep_req, .os_sleep_type,
      .os_s4_wake_ok, .deepest_sleep_option, .ac_restore_mode, .last_state_on, .led_dual_colour,
      .lan_monitor_en, .system_on_r, .pwr_out, .state);

   initial begin
      forever #4 clk = ~clk;
   end

   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic boot(input logic [1:0] mode, input logic last);
      resetn = 1'b0;
      ac_restore_mode = mode;
      last_state_on = last;
      step(12);
      resetn = 1'b1;
      step(3);
   endtask

   task automatic go_sleep(input logic [1:0] kind);
      os_sleep_type = kind;
      os_sleep_req = 1'b1;
      step(1);
      os_sleep_req = 1'b0;
      step(2);
   endtask

   task automatic t_ac_restore;
      for (int m = 0; m < 4; m++) begin
         for (int l = 0; l < 2; l++) begin
            boot(2'(m), 1'(l));
            chk(system_on_r, m == 1 || (m == 2 && l == 1), "ac restore");
            chk(pwr_out, (m == 1 || (m == 2 && l == 1)) ? 4'hE : 4'h0, "restore outputs");
         end
      end
   endtask

   // every source but the power switch from every sleep state, plain, deep-limited, and without os s4 support
   task automatic t_wake_matrix;
      logic wk;
      for (int c = 0; c < 3; c++) begin
         for (int t = 0; t < 3; t++) begin
            for (int s = 0; s < 5; s++) begin
               deepest_sleep_option = c == 1;
               os_s4_wake_ok = c != 2;
               led_dual_colour = s[0];
               boot(AC_POWER_ON, 1'b0);
               go_sleep(2'(t));
               chk(state, 4'h2 << t, "sleep state");
               chk(pwr_out, t == 0 ? {3'h2, led_dual_colour} : 4'h0, "supply and led");
               chk(lan_monitor_en, !(deepest_sleep_option && t != 0), "lan monitor");
               cmd = 6'h01 << s;
               step(2);
               wk = t == 0 || (s != 2 && (t != 1 || os_s4_wake_ok) && (!deepest_sleep_option || s == 4));
               chk(system_on_r, wk, "wake");
               chk(pwr_out, wk ? 4'hE : (t == 0 ? {3'h2, led_dual_colour} : 4'h0), "outputs after wake");
               cmd = 6'h00;
               step(2);
            end
         end
      end
   endtask

   task automatic t_wake_in_s0;
      boot(AC_POWER_ON, 1'b0);
      cmd = 6'h10;
      step(2);
      cmd = 6'h00;
      step(2);
      go_sleep(REQ_S3);
      chk(state, ST_S3, "no stale wake");
      step(4);
      chk(state, ST_S3, "still asleep");
      go_sleep(REQ_S5);
      chk(state, ST_S3, "request ignored asleep");
      boot(AC_POWER_ON, 1'b0);
      go_sleep(2'h3);
      chk(state, ST_S5, "soft-off code three");
   endtask

   task automatic stop_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      t_ac_restore();
      t_wake_matrix();
      t_wake_in_s0();
      stop_test();
   end

   // tests need about 1200 cycles; 40 us is several times that
   initial begin
      #40000;
      fails++;
      stop_test();
   end
endmodule
